//--- hw/acs_clock_divider.v
// Pre-divider and divider stage for the conversion clock
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_clock_divider (
  input  wire       clock_in,
  input  wire       rst_n_in,
  input  wire       enable_in,
  input  wire       tick_in,
  input  wire [1:0] predivider_in,
  input  wire [2:0] divider_in,
  output reg        conv_tick_out
);
  reg [`ACS_CNT_W-1:0] pre_cnt_reg;
  reg [`ACS_CNT_W-1:0] pre_lim;
  reg [2:0]            div_cnt_reg;
  wire                 pre_tick;

  // Pre-divider limit per code
  always @* begin
    case (predivider_in)
      `ACS_PDIV_1:  pre_lim = `ACS_PLIM_1;
      `ACS_PDIV_4:  pre_lim = `ACS_PLIM_4;
      `ACS_PDIV_32: pre_lim = `ACS_PLIM_32;
      default:      pre_lim = `ACS_PLIM_64;
    endcase
  end

  assign pre_tick = tick_in && (pre_cnt_reg >= pre_lim);

  // Counters use >= so a shrinking ratio never strands them (no hang)
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_cnt_reg   <= 6'h00;
      div_cnt_reg   <= 3'h0;
      conv_tick_out <= 1'b0;
    end else if (!enable_in) begin
      pre_cnt_reg   <= 6'h00;
      div_cnt_reg   <= 3'h0;
      conv_tick_out <= 1'b0;
    end else begin
      conv_tick_out <= 1'b0;
      if (tick_in) begin
        pre_cnt_reg <= pre_tick ? 6'h00 : pre_cnt_reg + 6'h01;
      end
      if (pre_tick) begin
        if (div_cnt_reg >= divider_in) begin
          div_cnt_reg   <= 3'h0;
          conv_tick_out <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end
endmodule

//--- hw/acs_sequencer.v
// Conversion sequencer control: registers, triggers, clocking and reference ownership
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "acs_defines.vh"
module acs_sequencer (
  input  wire                   clock_in,
  input  wire                   rst_n_in,
  input  wire                   clk_en_in,
  input  wire [`ACS_ADDR_W-1:0] addr_in,
  input  wire [15:0]            wdata_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  output reg  [15:0]            rdata_out,
  input  wire                   timer_trig_in,
  input  wire                   aux_clk_tick_in,
  input  wire                   main_clk_tick_in,
  input  wire                   osc_clk_tick_in,
  input  wire                   sub_clk_tick_in,
  input  wire                   conv_done_in,
  input  wire                   seq_last_in,
  output reg                    conv_start_out,
  output reg                    conv_clk_tick_out,
  output reg  [3:0]             clk_request_out,
  output reg                    conversion_active_flag_out,
  output reg                    shared_ref_on_out,
  output reg                    shared_ref_output_out,
  output reg                    irq_out
);
  // ==========================================================
  // Reset release and input synchronisers
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  wire       rst_n = rst_s2_reg;
  reg        trig_s1_reg;
  reg        trig_s2_reg;
  reg        trig_s3_reg;
  reg [3:0]  tk_s1_reg;
  reg [3:0]  tk_s2_reg;
  reg        done_s1_reg;
  reg        done_s2_reg;
  reg        last_s1_reg;
  reg        last_s2_reg;

  // Two-stage release of the asynchronous reset
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Pin inputs pass two flip-flops; timer gets a third for edge detection
  always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
      tk_s1_reg   <= 4'h0;
      tk_s2_reg   <= 4'h0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      last_s1_reg <= 1'b0;
      last_s2_reg <= 1'b0;
    end else if (clk_en_in) begin
      trig_s1_reg <= timer_trig_in;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      tk_s1_reg   <= {sub_clk_tick_in, osc_clk_tick_in, main_clk_tick_in, aux_clk_tick_in};
      tk_s2_reg   <= tk_s1_reg;
      done_s1_reg <= conv_done_in;
      done_s2_reg <= done_s1_reg;
      last_s1_reg <= seq_last_in;
      last_s2_reg <= last_s1_reg;
    end
  end

  // ==========================================================
  // Registers
  reg [15:0] ctl0_reg;
  reg [15:0] ctl1_reg;
  reg [15:0] ref_reg;
  reg [1:0]  stat_reg;
  reg [1:0]  mask_reg;
  reg [1:0]  state_reg;
  reg        arm_rise_reg;
  wire       wr_ctl0 = wr_in && (addr_in == `ACS_OFF_CTL0);
  wire       arm     = ctl0_reg[`ACS_B_ARM];
  wire       pwr     = ctl0_reg[`ACS_B_ON];
  wire       shp     = ctl1_reg[`ACS_B_SHP];
  wire [1:0] seq     = ctl1_reg[`ACS_F_SEQ];
  wire       timer_edge = trig_s2_reg && !trig_s3_reg;
  wire       sw_trig;
  wire       trig;
  wire       running = (state_reg != `ACS_IDLE);
  wire       done_evt;
  wire       last_done;
  wire [1:0] stat_set;

  // Software start only counts in manual mode with arm and power set
  assign sw_trig = wr_ctl0 && wdata_in[`ACS_B_SC] && !shp;
  // Timer trigger in single mode waits for a fresh arm write
  assign trig = arm && pwr && (sw_trig ||
                (shp && timer_edge && (seq != `ACS_SEQ_SINGLE || arm_rise_reg)));
  assign done_evt  = running && done_s2_reg;
  assign last_done = done_evt && (seq == `ACS_SEQ_SINGLE || last_s2_reg ||
                     !(seq[1] || seq[0]));
  assign stat_set  = {done_evt, trig && running};

  // Register writes; hardware sets win over software clears
  always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctl0_reg     <= `ACS_ZERO16;
      ctl1_reg     <= `ACS_ZERO16;
      ref_reg      <= `ACS_ZERO16;
      stat_reg     <= `ACS_ZERO2;
      mask_reg     <= `ACS_ZERO2;
      arm_rise_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_ctl0) begin
        ctl0_reg <= wdata_in & 16'hFFFE; // Start bit self-clears
      end
      if (wr_in && addr_in == `ACS_OFF_CTL1) begin
        ctl1_reg <= wdata_in;
      end
      if (wr_in && addr_in == `ACS_OFF_REF) begin
        ref_reg <= wdata_in;
      end
      if (wr_in && addr_in == `ACS_OFF_MASK) begin
        mask_reg <= wdata_in[1:0];
      end
      if (wr_in && addr_in == `ACS_OFF_STAT) begin
        stat_reg <= (stat_reg & ~wdata_in[1:0]) | stat_set;
      end else begin
        stat_reg <= stat_reg | stat_set;
      end
      // Only a 0-to-1 write of arm re-arms; writes with arm clear or a timer trigger drop it
      if (wr_ctl0 && wdata_in[`ACS_B_ARM] && !arm) begin
        arm_rise_reg <= 1'b1;
      end else if (!arm || (wr_ctl0 && !wdata_in[`ACS_B_ARM]) || (trig && shp)) begin
        arm_rise_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sequencer: overrun never stalls, power/arm drop recovers
  always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= `ACS_IDLE;
      conv_start_out <= 1'b0;
    end else if (clk_en_in) begin
      conv_start_out <= 1'b0;
      case (state_reg)
        `ACS_IDLE: begin
          if (trig) begin
            state_reg      <= `ACS_CONV;
            conv_start_out <= 1'b1;
          end
        end
        `ACS_CONV: begin
          if (!pwr || !arm) begin
            state_reg <= `ACS_IDLE;
          end else if (last_done) begin
            state_reg <= `ACS_IDLE;
          end else if (done_evt) begin
            conv_start_out <= 1'b1;
          end
        end
        default: state_reg <= `ACS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Clock selection and division
  reg        src_tick;
  wire       div_tick;
  always @* begin
    case (ctl1_reg[`ACS_F_SSEL])
      `ACS_SSEL_AUX:  src_tick = tk_s2_reg[0];
      `ACS_SSEL_MAIN: src_tick = tk_s2_reg[1];
      `ACS_SSEL_OSC:  src_tick = tk_s2_reg[2];
      default:        src_tick = tk_s2_reg[3];
    endcase
  end

  acs_clock_divider u_div (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n),
    .enable_in     (pwr),
    .tick_in       (src_tick && clk_en_in), // Counters hold while the clock enable is low
    .predivider_in (ctl1_reg[`ACS_F_PDIV]),
    .divider_in    (ctl1_reg[`ACS_F_DIV]),
    .conv_tick_out (div_tick)
  );

  // ==========================================================
  // Outputs, reference ownership and read port
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_req
      // One-hot request to the selected source while armed
      always @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
          clk_request_out[gi] <= 1'b0;
        end else if (clk_en_in) begin
          clk_request_out[gi] <= arm && (ctl1_reg[`ACS_F_SSEL] == gi);
        end
      end
    end
  endgenerate

  always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_clk_tick_out          <= 1'b0;
      conversion_active_flag_out <= 1'b0;
      shared_ref_on_out          <= 1'b0;
      shared_ref_output_out      <= 1'b0;
      irq_out                    <= 1'b0;
      rdata_out                  <= `ACS_ZERO16;
    end else if (clk_en_in) begin
      conv_clk_tick_out          <= div_tick && running;
      conversion_active_flag_out <= running || trig;
      if (ref_reg[`ACS_B_ROWN]) begin
        shared_ref_on_out     <= ref_reg[`ACS_B_MREFON];
        shared_ref_output_out <= ref_reg[`ACS_B_MREFOUT];
      end else begin
        shared_ref_on_out     <= ctl0_reg[`ACS_B_REFON];
        shared_ref_output_out <= ctl0_reg[`ACS_B_REFOUT];
      end
      irq_out <= |(stat_reg & mask_reg);
      if (rd_in) begin
        case (addr_in)
          `ACS_OFF_CTL0: rdata_out <= ctl0_reg;
          `ACS_OFF_CTL1: rdata_out <= ctl1_reg;
          `ACS_OFF_REF:  rdata_out <= ref_reg;
          `ACS_OFF_STAT: rdata_out <= {13'h0000, conversion_active_flag_out, stat_reg};
          `ACS_OFF_MASK: rdata_out <= {14'h0000, mask_reg};
          default:       rdata_out <= `ACS_ZERO16;
        endcase
      end else begin
        rdata_out <= `ACS_ZERO16;
      end
    end
  end
endmodule

//--- shared/acs_defines.vh
// Constants for the conversion sequencer control block
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// ==========================================================
// Register offsets
`define ACS_ADDR_W      4
`define ACS_OFF_CTL0    4'h0
`define ACS_OFF_CTL1    4'h1
`define ACS_OFF_REF     4'h2
`define ACS_OFF_STAT    4'h3
`define ACS_OFF_MASK    4'h4
// ==========================================================
// Word 0 fields
`define ACS_B_SC        0
`define ACS_B_ARM       1
`define ACS_B_ON        4
`define ACS_B_REFON     5
`define ACS_B_REFOUT    6
// Word 1 fields
`define ACS_B_SHP       0
`define ACS_F_SEQ       2:1
`define ACS_F_SSEL      4:3
`define ACS_F_DIV       7:5
`define ACS_F_PDIV      9:8
// Reference word fields
`define ACS_B_ROWN      0
`define ACS_B_MREFON    1
`define ACS_B_MREFOUT   2
// Status bits
`define ACS_B_OVR       0
`define ACS_B_DONE      1
// ==========================================================
// Encodings and resets
`define ACS_SEQ_SINGLE  2'h0
`define ACS_SSEL_AUX    2'h0
`define ACS_SSEL_MAIN   2'h1
`define ACS_SSEL_OSC    2'h2
`define ACS_SSEL_SUB    2'h3
`define ACS_PDIV_1      2'h0
`define ACS_PDIV_4      2'h1
`define ACS_PDIV_32     2'h2
`define ACS_PDIV_64     2'h3
// Pre-divider terminal counts, one less than the ratio
`define ACS_PLIM_1      6'h00
`define ACS_PLIM_4      6'h03
`define ACS_PLIM_32     6'h1F
`define ACS_PLIM_64     6'h3F
`define ACS_CNT_W       6
`define ACS_ZERO16      16'h0000
`define ACS_ZERO2       2'h0
`define ACS_ONE2        2'h1
`define ACS_IDLE        2'h0
`define ACS_CONV        2'h1
`define ACS_WAITDONE    2'h2
`endif

//--- tb/acs_core_model.sv
// Behavioural converter core that answers each start after a set delay
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic       busy_in,
  input  wire logic [7:0] delay_in,
  input  wire logic [1:0] seq_len_in,
  output logic            done_out,
  output logic            last_out
);
  logic [7:0] wait_reg;
  logic       run_reg;
  logic [1:0] cnt_reg;
  // Result stored one delay after each start, as a one-cycle pulse
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_reg <= 1'b0;
      wait_reg <= 8'h00;
      done_out <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      done_out <= run_reg && wait_reg == 8'h00;
      if (start_in) begin
        run_reg <= 1'b1;
        wait_reg <= delay_in;
      end else if (wait_reg != 8'h00) begin
        wait_reg <= wait_reg - 8'h01;
      end else begin
        run_reg <= 1'b0;
      end
      // Position in the sequence, cleared once the sequencer idles
      if (!busy_in) cnt_reg <= 2'h0;
      else if (done_out) cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign last_out = cnt_reg == seq_len_in;
endmodule

//--- tb/acs_sequencer_props.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module acs_sequencer_props (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [3:0]  addr_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        conv_done_in,
  input wire logic        conv_start_out,
  input wire logic [3:0]  clk_request_out,
  input wire logic        conversion_active_flag_out,
  input wire logic        shared_ref_on_out,
  input wire logic        shared_ref_output_out
);
  // ==========
  // Clocking shared by every check
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside read slot");
  chk_unmapped_read: assert property ($past(rd_in && addr_in > 4'h4) |-> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  chk_status_busy_bit: assert property ($past(rd_in && addr_in == 4'h3) |->
    rdata_out[2] == $past(conversion_active_flag_out))
    else $error("status busy bit wrong");
  chk_start_sets_busy: assert property (conv_start_out |-> conversion_active_flag_out)
    else $error("start without busy");
  chk_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse too long");
  chk_busy_rise_start: assert property ($rose(conversion_active_flag_out) |-> conv_start_out)
    else $error("busy rose without start");
  chk_start_has_request: assert property (conv_start_out |-> clk_request_out != 4'h0)
    else $error("start without clock request");
  chk_request_onehot: assert property ($onehot0(clk_request_out))
    else $error("clock request not one-hot");
  chk_request_by_write: assert property ($changed(clk_request_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("clock request moved without write");
  chk_ref_by_write: assert property ($changed({shared_ref_on_out, shared_ref_output_out}) |->
    $past(wr_in) || $past(wr_in, 2))
    else $error("reference moved without write");
  chk_busy_holds_on: assert property (conversion_active_flag_out && !conv_done_in && !$past(conv_done_in)
    && !$past(conv_done_in, 2) && !$past(conv_done_in, 3) && !wr_in && !$past(wr_in) && !$past(wr_in, 2) |=>
    conversion_active_flag_out)
    else $error("busy dropped early");
endmodule
bind acs_sequencer acs_sequencer_props chk_i (.*);

//--- tb/acs_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_tb_top;
  logic        clock_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, trig = 0, done, last, cen = 1;
  logic        start, ctick, busy, ron, rout, irq;
  logic [3:0]  addr_in = 0, ticks = 0, req;
  logic [15:0] wdata_in = 0, rv;
  wire  [15:0] rdata_out;
  logic [7:0]  dly = 8'h08;
  logic [1:0]  slen = 2'h0;
  logic [4:0]  cfg [7] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h09, 5'h10, 5'h18};
  logic [31:0] seed = 32'd58805;
  int          mismatches = 0, checks_done = 0, starts = 0, n, i, k;
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in) if (start === 1'b1) starts <= starts + 1;
  acs_sequencer dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(cen), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .timer_trig_in(trig),
    .aux_clk_tick_in(ticks[0]), .main_clk_tick_in(ticks[1]), .osc_clk_tick_in(ticks[2]),
    .sub_clk_tick_in(ticks[3]), .conv_done_in(done), .seq_last_in(last), .conv_start_out(start),
    .conv_clk_tick_out(ctick), .clk_request_out(req), .conversion_active_flag_out(busy),
    .shared_ref_on_out(ron), .shared_ref_output_out(rout), .irq_out(irq));
  acs_core_model core (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start), .busy_in(busy),
    .delay_in(dly), .seq_len_in(slen), .done_out(done), .last_out(last));
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic int ratio(input logic [4:0] c);
    return (c[4:3] == 0 ? 1 : c[4:3] == 1 ? 4 : c[4:3] == 2 ? 32 : 64) * (c[2:0] + 1);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clock_in);
    #1;
  endtask
  task automatic wait_busy(input logic v);
    k = 0;
    while (busy !== v && k < 700) begin
      settle(1);
      k++;
    end
    chk(busy, v);
  endtask
  task automatic pulse;
    @(posedge clock_in);
    trig <= 1'b1;
    repeat (4) @(posedge clock_in);
    trig <= 1'b0;
    settle(8);
  endtask
  // Count divided ticks over a window against the programmed ratio
  task automatic count_ticks(input int w, input int r);
    n = 0;
    repeat (w) begin
      settle(1);
      if (ctick === 1'b1) n++;
    end
    chk(n >= w / r - 2 && n <= w / r + 2, 1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    test_done;
  end
  // ==========
  // Scenarios
  initial begin
    settle(16);
    rst_n_in <= 1'b1;
    settle(3);
    for (i = 0; i < 16; i++) begin
      rd(i[3:0], rv);
      chk(rv, 16'h0000);
    end
    chk({start, busy, req, ron, rout, irq}, 16'h0000);
    $display("done: reset");
    wr(4'h0, 16'h0012);
    n = starts;
    wr(4'h0, 16'h0013);
    wait_busy(1);
    wait_busy(0);
    chk(16'(starts - n), 16'h0001);
    settle(3);
    rd(4'h3, rv);
    chk(rv, 16'h0002);
    chk(irq, 0);
    wr(4'h4, 16'h0002);
    settle(3);
    chk(irq, 1);
    wr(4'h3, 16'h0002);
    settle(3);
    chk(irq, 0);
    $display("done: software start");
    slen = 2'h2;
    dly = 8'h20;
    for (i = 1; i < 4; i++) begin
      wr(4'h1, 16'(i << 1));
      n = starts;
      wr(4'h0, 16'h0013);
      wr(4'h0, 16'h0013);
      wait_busy(0);
      chk(16'(starts - n), 16'h0003);
      rd(4'h3, rv);
      chk(rv, 16'h0003);
      wr(4'h3, 16'h0003);
    end
    $display("done: overrun");
    slen = 2'h0;
    dly = 8'hC8;
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0013);
    wait_busy(1);
    wr(4'h0, 16'h0000);
    wait_busy(0);
    wr(4'h0, 16'h0012);
    n = starts;
    wr(4'h0, 16'h0013);
    wait_busy(1);
    wait_busy(0);
    chk(16'(starts - n), 16'h0001);
    $display("done: recovery");
    dly = 8'h08;
    wr(4'h1, 16'h0001);
    n = starts;
    for (i = 0; i < 3; i++) begin
      if (i != 1) wr(4'h0, 16'h0010);
      wr(4'h0, i == 1 ? 16'h0032 : 16'h0012);
      pulse;
      wait_busy(0);
    end
    chk(16'(starts - n), 16'h0002);
    $display("done: timer arming");
    for (i = 0; i < 4; i++) begin
      wr(4'h1, 16'(i << 3));
      wr(4'h0, 16'h0012);
      settle(2);
      chk(req, 16'(1 << i));
      wr(4'h0, 16'h0010);
      settle(2);
      chk(req, 16'h0000);
    end
    $display("done: clock request");
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(4'h2, {13'h0, seed[2:0]});
      wr(4'h0, {9'h0, seed[4:3], 5'h10});
      settle(2);
      chk({ron, rout}, seed[0] ? {seed[1], seed[2]} : {seed[3], seed[4]});
    end
    $display("done: reference owner");
    // A write while the clock enable is low must leave the mask untouched
    @(posedge clock_in);
    cen <= 1'b0;
    wr(4'h4, 16'h0001);
    cen <= 1'b1;
    rd(4'h4, rv);
    chk(rv, 16'h0002);
    $display("done: clock enable");
    ticks <= 4'hF;
    dly = 8'hFF;
    for (i = 0; i < 10; i++) begin
      wr(4'h1, {6'h0, i < 7 ? cfg[i] : 5'(2 * i - 12), 2'h3, 3'h0});
      wr(4'h0, 16'h0012);
      wr(4'h0, 16'h0013);
      wait_busy(1);
      @(posedge clock_in);
      if (i > 6) ticks <= 4'h7;
      if (i > 6) wr(4'h1, 16'(((2 * i - 12) << 5) | 8));
      count_ticks(i < 7 ? 200 : 150, i < 7 ? ratio(cfg[i]) : 2 * i - 11);
      wait_busy(0);
      ticks <= 4'hF;
    end
    $display("done: clock divider");
    test_done;
  end
endmodule
